/* verilog/cpc_channel_protect.sv */
`timescale 1ns/1ps
`include "cpc_consts.svh"
// How it works
// - Ten control inputs, each gating only its own channel stage.
// - Low control input switches the matching channel off.
// - Fault arriving during diagnosis write is held, stored after write.
// - Overcurrent or overtemperature latches channel off until diagnosis cleared.
// - Reverse comparator inactive unless enable bit set.
// - Enabled comparator turns channel on when reverse current seen.
// - Channel kept on while reverse current below switch-off threshold.
// - Above threshold the comparator releases channel to other protection.
// - After trip comparator stays off until reverse current is zero.
// - After reverse current returns to zero, wait re-arm delay.
// - Above high threshold, switch off after short overload delay.
// - Above low threshold, switch off after long overload delay.
// - Fault reported in two-bit diagnosis field as code 10.
// - Re-arm delay is 24 microseconds.
module cpc_channel_protect (
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_in,
   input  wire logic [`CPC_NUM_CH-1:0]        direct_control_input_in,
   input  wire cpc_pkg::cpc_sense_t [`CPC_NUM_CH-1:0] sense_in,
   input  wire logic                          reverse_protect_enable_in,
   input  wire logic                          diag_write_busy_in,
   input  wire logic [`CPC_NUM_CH-1:0]        diag_clear_in,
   output logic [`CPC_NUM_CH-1:0]             output_channel_out,
   output logic [2*`CPC_NUM_CH-1:0]           diag_out,
   output logic [`CPC_NUM_CH-1:0]             overcurrent_overtemp_fault_out,
   output logic [`CPC_NUM_CH-1:0]             comparator_active_out
);
   localparam int N = `CPC_NUM_CH;
   localparam logic [`CPC_TMR_W-1:0] SHORT_CYC = `CPC_TMR_W'(`CPC_SHORT_CYC);
   localparam logic [`CPC_TMR_W-1:0] LONG_CYC  = `CPC_TMR_W'(`CPC_LONG_CYC);
   localparam logic [`CPC_TMR_W-1:0] REARM_CYC = `CPC_TMR_W'(`CPC_REARM_CYC);

   // Three-stage synchroniser
   logic [N-1:0]              s1_q, s2_q, s3_q, in_q;
   logic [N-1:0]              s1_d, s2_d, s3_d, in_d;
   // Fault latch, deferred event and diagnosis field
   logic [N-1:0]              fault_q, fault_d;
   logic [N-1:0]              pend_q, pend_d;
   logic [2*N-1:0]            diag_q, diag_d;
   // Output stage drive
   logic [N-1:0]              out_q, out_d;
   // Overload delay counters
   logic [`CPC_TMR_W-1:0]     hi_q [N];
   logic [`CPC_TMR_W-1:0]     hi_d [N];
   logic [`CPC_TMR_W-1:0]     lo_q [N];
   logic [`CPC_TMR_W-1:0]     lo_d [N];
   logic [N-1:0]              evt;
   // Reverse-current comparator
   cpc_pkg::cpc_rc_state_t    rc_q [N];
   cpc_pkg::cpc_rc_state_t    rc_d [N];
   logic [`CPC_TMR_W-1:0]     rc_t_q [N];
   logic [`CPC_TMR_W-1:0]     rc_t_d [N];
   logic [N-1:0]              cmp_q, cmp_d;
   logic [N-1:0]              rc_on;

   function automatic logic [`CPC_TMR_W-1:0] tick(
      input logic [`CPC_TMR_W-1:0] v,
      input logic                  run
   );
      // Saturating count, cleared whenever the condition drops
      if (!run) begin
         tick = '0;
      end else if (v == '1) begin
         tick = v;
      end else begin
         tick = v + `CPC_TMR_W'(1);
      end
   endfunction

   function automatic logic expired(
      input logic [`CPC_TMR_W-1:0] v,
      input logic [`CPC_TMR_W-1:0] lim
   );
      expired = (v >= lim - `CPC_TMR_W'(1));
   endfunction

   function automatic logic [N-1:0] settle(
      input logic [N-1:0] late_a,
      input logic [N-1:0] late_b,
      input logic [N-1:0] held
   );
      // Per channel, so one restless pin never stalls another
      settle = (~(late_a ^ late_b) & late_b) | ((late_a ^ late_b) & held);
   endfunction

   // Pin synchroniser and agreement filter
   always_comb begin
      s1_d = direct_control_input_in;
      s2_d = s1_q;
      s3_d = s2_q;
      in_d = settle(s2_q, s3_q, in_q);
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         in_q <= '0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         in_q <= in_d;
      end
   end

   // Overload timers only run while the stage conducts
   always_comb begin
      evt = '0;
      for (int i = 0; i < N; i++) begin
         hi_d[i] = tick(hi_q[i], sense_in[i].high_over & out_q[i]);
         lo_d[i] = tick(lo_q[i], sense_in[i].low_over & out_q[i]);
         evt[i]  = sense_in[i].overtemp
                 | (expired(hi_q[i], SHORT_CYC) & sense_in[i].high_over)
                 | (expired(lo_q[i], LONG_CYC) & sense_in[i].low_over);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         for (int i = 0; i < N; i++) begin
            hi_q[i] <= '0;
            lo_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            hi_q[i] <= hi_d[i];
            lo_q[i] <= lo_d[i];
         end
      end
   end

   // Reverse-current comparator sequencing
   always_comb begin
      cmp_d = '0;
      rc_on = '0;
      for (int i = 0; i < N; i++) begin
         rc_d[i]   = rc_q[i];
         rc_t_d[i] = rc_t_q[i];
         unique case (rc_q[i])
            cpc_pkg::CPC_RC_IDLE: begin
               if (reverse_protect_enable_in && sense_in[i].rev_det) begin
                  rc_d[i] = cpc_pkg::CPC_RC_ACTIVE;
               end
            end
            cpc_pkg::CPC_RC_ACTIVE: begin
               if (!reverse_protect_enable_in) begin
                  rc_d[i] = cpc_pkg::CPC_RC_IDLE;
               end else if (sense_in[i].rev_over) begin
                  rc_d[i] = cpc_pkg::CPC_RC_TRIP;
               end else if (!sense_in[i].rev_det) begin
                  rc_d[i] = cpc_pkg::CPC_RC_IDLE;
               end
            end
            cpc_pkg::CPC_RC_TRIP: begin
               rc_t_d[i] = '0;
               if (!sense_in[i].rev_det) begin
                  rc_d[i] = cpc_pkg::CPC_RC_REARM;
               end
            end
            cpc_pkg::CPC_RC_REARM: begin
               rc_t_d[i] = tick(rc_t_q[i], 1'b1);
               if (sense_in[i].rev_det) begin
                  rc_d[i] = cpc_pkg::CPC_RC_TRIP;
               end else if (expired(rc_t_q[i], REARM_CYC)) begin
                  rc_d[i] = cpc_pkg::CPC_RC_IDLE;
               end
            end
         endcase
         cmp_d[i] = (rc_d[i] == cpc_pkg::CPC_RC_ACTIVE);
         rc_on[i] = (rc_q[i] == cpc_pkg::CPC_RC_ACTIVE);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cmp_q <= '0;
         for (int i = 0; i < N; i++) begin
            rc_q[i]   <= cpc_pkg::CPC_RC_IDLE;
            rc_t_q[i] <= '0;
         end
      end else begin
         cmp_q <= cmp_d;
         for (int i = 0; i < N; i++) begin
            rc_q[i]   <= rc_d[i];
            rc_t_q[i] <= rc_t_d[i];
         end
      end
   end

   // Fault latch; a new event beats a clear in the same cycle
   always_comb begin
      fault_d = fault_q;
      pend_d  = pend_q;
      diag_d  = diag_q;
      for (int i = 0; i < N; i++) begin
         if (diag_clear_in[i] && !diag_write_busy_in) begin
            diag_d[2*i +: 2] = `CPC_DIAG_NONE;
            fault_d[i]       = 1'b0;
         end
         if (evt[i] || pend_q[i]) begin
            fault_d[i] = 1'b1;
            if (diag_write_busy_in) begin
               pend_d[i] = 1'b1;
            end else begin
               diag_d[2*i +: 2] = `CPC_DIAG_OCT;
               pend_d[i]        = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         fault_q <= '0;
         pend_q  <= '0;
         diag_q  <= '0;
      end else begin
         fault_q <= fault_d;
         pend_q  <= pend_d;
         diag_q  <= diag_d;
      end
   end

   // Stage drive: pin request unless latched off, clamp overrides
   always_comb begin
      out_d = '0;
      for (int i = 0; i < N; i++) begin
         out_d[i] = (in_q[i] & ~fault_q[i] & ~evt[i]) | rc_on[i];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   assign output_channel_out             = out_q;
   assign diag_out                       = diag_q;
   assign overcurrent_overtemp_fault_out = fault_q;
   assign comparator_active_out          = cmp_q;
endmodule // cpc_channel_protect

/* shared/cpc_consts.svh */
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH
`define CPC_NUM_CH        10
`define CPC_CLK_MHZ       25
`define CPC_SHORT_DLY_US  21
`define CPC_LONG_DLY_US   40
`define CPC_REARM_DLY_US  24
`define CPC_SHORT_CYC     (`CPC_SHORT_DLY_US * `CPC_CLK_MHZ)
`define CPC_LONG_CYC      (`CPC_LONG_DLY_US * `CPC_CLK_MHZ)
`define CPC_REARM_CYC     (`CPC_REARM_DLY_US * `CPC_CLK_MHZ)
`define CPC_TMR_W         11
`define CPC_DIAG_OCT      2'b10
`define CPC_DIAG_NONE     2'b00
`endif

/* shared/cpc_pkg.sv */
package cpc_pkg;
   typedef enum logic [1:0] {
      CPC_RC_IDLE   = 2'b00,
      CPC_RC_ACTIVE = 2'b01,
      CPC_RC_TRIP   = 2'b10,
      CPC_RC_REARM  = 2'b11
   } cpc_rc_state_t;

   typedef struct packed {
      logic high_over;
      logic low_over;
      logic overtemp;
      logic rev_det;
      logic rev_over;
   } cpc_sense_t;
endpackage

/* verification/cpc_chk_assertions.sv */
`timescale 1ns/1ps
module cpc_chk (
   input wire logic                      clk_sys_in,
   input wire logic                      rst_in,
   input wire logic [9:0]                direct_control_input_in,
   input wire cpc_pkg::cpc_sense_t [9:0] sense_in,
   input wire logic                      reverse_protect_enable_in,
   input wire logic                      diag_write_busy_in,
   input wire logic [9:0]                output_channel_out,
   input wire logic [19:0]               diag_out,
   input wire logic [9:0]                overcurrent_overtemp_fault_out,
   input wire logic [9:0]                comparator_active_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   a_pin_gate: assert property ((output_channel_out & ~($past(comparator_active_out) |
      $past(direct_control_input_in, 4) | $past(direct_control_input_in, 5) |
      $past(direct_control_input_in, 6))) == '0) else $error("channel on without request");
   a_diag_code: assert property ((diag_out & 20'h5_5555) == '0)
      else $error("diag code not 10 or 00");
   a_ot_latch: assert property (sense_in[0].overtemp |=> overcurrent_overtemp_fault_out[0] &&
      (!output_channel_out[0] || $past(comparator_active_out[0]))) else $error("no fault latch");
   a_busy_hold: assert property (diag_write_busy_in |=> $stable(diag_out))
      else $error("diag moved while busy");
   a_pend_store: assert property (diag_write_busy_in && sense_in[0].overtemp ##1
      !diag_write_busy_in |=> diag_out[1]) else $error("held event lost");
   a_rc_cause: assert property ($rose(comparator_active_out[0]) |->
      $past(reverse_protect_enable_in) && $past(sense_in[0].rev_det)) else $error("bad clamp");
   a_rc_trip: assert property (comparator_active_out[0] && sense_in[0].rev_over |=>
      !comparator_active_out[0] && output_channel_out[0]) else $error("clamp not tripped");
   a_rc_stay: assert property ($fell(comparator_active_out[0]) &&
      $past(sense_in[0].rev_over) && $past(reverse_protect_enable_in) |=>
      (!comparator_active_out[0]) [*8]) else $error("clamp back too soon");
endmodule // cpc_chk
bind cpc_channel_protect cpc_chk i_chk (.*);

/* verification/cpc_host_model.sv */
`timescale 1ns/1ps
module cpc_host_model (
   input  wire logic       clk_sys_in,
   input  wire logic [9:0] want_in,
   output logic      [9:0] pins_out
);
   // Host port moves just after the edge
   always @(posedge clk_sys_in) pins_out <= #1 want_in;
endmodule // cpc_host_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "cpc_consts.svh"
module tb_top;
   logic                      clk_sys_in = 1'b0, rst_in = 1'b1, en = 1'b0, busy = 1'b0;
   logic [9:0]                want = '0, clr = '0, pins, out, flt, cmp;
   logic [19:0]               diag;
   cpc_pkg::cpc_sense_t [9:0] sense = '0;
   int                        n_errors = 0, tests_run = 0, k;
   initial forever #20 clk_sys_in = ~clk_sys_in;
   cpc_host_model i_host (.clk_sys_in(clk_sys_in), .want_in(want), .pins_out(pins));
   cpc_channel_protect i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .direct_control_input_in(pins), .sense_in(sense), .reverse_protect_enable_in(en),
      .diag_write_busy_in(busy), .diag_clear_in(clr), .output_channel_out(out),
      .diag_out(diag), .overcurrent_overtemp_fault_out(flt), .comparator_active_out(cmp));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string nm);
      tests_run++;
      if (seen !== exp) $display("ERROR %s exp %h seen %h", nm, exp, seen);
      if (seen !== exp) n_errors++;
   endtask
   function automatic logic [19:0] exp_diag(input logic [9:0] f);
      for (int i = 0; i < 10; i++) exp_diag[2*i+:2] = {f[i], 1'b0};
   endfunction
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      tick(6000);
      n_errors++;
      complete_run;
   end
   initial begin
      void'($urandom(32'ha8c2_4cd9));
      tick(20);
      rst_in = 1'b0;
      for (int i = 0; i < 12; i++) begin
         want = (i == 11) ? 10'h3ff : (i == 0) ? '0 : 10'($urandom);
         tick(8);
         chk(out, want, "out");
      end
      $display("pin test done");
      busy = 1'b1;
      sense[0].overtemp = 1'b1;
      tick(1);
      sense[0].overtemp = 1'b0;
      clr = 10'h001;
      tick(3);
      chk(diag, '0, "held diag");
      chk(out, 10'h3fe, "latched out");
      clr = '0;
      busy = 1'b0;
      tick(2);
      chk(diag, exp_diag(10'h001), "diag");
      for (int j = 0; j < 3; j++) begin
         if (j > 0) k = $urandom_range(9);
         if (j > 0) sense[k].low_over = 1'b1;
         if (j > 0) sense[k].high_over = (j == 1);
         tick((j == 1) ? `CPC_SHORT_CYC - 2 : `CPC_LONG_CYC - 2);
         if (j > 0) chk(flt, '0, "early");
         tick(4);
         if (j > 0) chk(out, 10'(~(10'h001 << k)), "tripped");
         if (j > 0) chk(diag, exp_diag(10'(10'h001 << k)), "trip diag");
         sense = '0;
         clr = 10'h3ff;
         tick(1);
         clr = '0;
         tick(7);
         chk(out, 10'h3ff, "re-on");
      end
      busy = 1'b1;
      sense[0].overtemp = 1'b1;
      tick(1);
      sense[0].overtemp = 1'b0;
      busy = 1'b0;
      tick(2);
      chk(diag, exp_diag(10'h001), "pend diag");
      chk(flt, 10'h001, "fault");
      clr = 10'h001;
      tick(1);
      clr = '0;
      tick(7);
      chk(diag, '0, "cleared diag");
      chk(out, 10'h3ff, "cleared");
      $display("overload test done");
      want = 10'h3fe;
      sense[0].rev_det = 1'b1;
      tick(8);
      chk(cmp, '0, "disabled");
      en = 1'b1;
      tick(3);
      chk(out, 10'h3ff, "clamp on");
      sense[0].rev_over = 1'b1;
      tick(3);
      chk(out, 10'h3fe, "clamp off");
      sense[0].rev_over = 1'b0;
      tick(50);
      chk(cmp, '0, "stays off");
      for (int j = 0; j < 2; j++) begin
         sense[0].rev_det = 1'b0;
         tick(j ? `CPC_REARM_CYC + 5 : `CPC_REARM_CYC - 5);
         sense[0].rev_det = 1'b1;
         tick(3);
         chk(cmp, 10'(j), "rearm");
      end
      $display("reverse test done");
      complete_run;
   end
endmodule // tb_top
